// ==== inc/ctm_pkg.sv ====
/*
  Package for the compact timer module: register offsets, field positions,
  reset values and mode encodings.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte offsets.
*/
package ctm_pkg;

  // ------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ------------------------------------------------------------
  localparam logic [4:0] CTM_OFS_CTRL0  = 5'h00; // Run, pause, clock select
  localparam logic [4:0] CTM_OFS_CTRL1  = 5'h04; // Mode, pin action, polarity
  localparam logic [4:0] CTM_OFS_CNT_LO = 5'h08; // Counter low byte
  localparam logic [4:0] CTM_OFS_CNT_HI = 5'h0C; // Counter high byte
  localparam logic [4:0] CTM_OFS_CMPA_L = 5'h10; // Compare-A low byte
  localparam logic [4:0] CTM_OFS_CMPA_H = 5'h14; // Compare-A high byte
  localparam logic [4:0] CTM_OFS_CMPP   = 5'h18; // Compare-P value
  localparam logic [4:0] CTM_OFS_FLAGS  = 5'h1C; // Event flags, write 1 clears

  // ------------------------------------------------------------
  // Control-0 field positions
  // ------------------------------------------------------------
  localparam int CTM_B_PAUSE = 7;
  localparam int CTM_B_CKHI  = 6;
  localparam int CTM_B_CKLO  = 4;
  localparam int CTM_B_RUN   = 3;

  // ------------------------------------------------------------
  // Control-1 field positions
  // ------------------------------------------------------------
  localparam int CTM_B_MODEHI = 7;
  localparam int CTM_B_MODELO = 6;
  localparam int CTM_B_PINHI  = 5;
  localparam int CTM_B_PINLO  = 4;
  localparam int CTM_B_OCTL   = 3;
  localparam int CTM_B_POL    = 2;
  localparam int CTM_B_DPX    = 1;
  localparam int CTM_B_CLRSEL = 0;

  // Flag register bits
  localparam int CTM_B_FLAG_A = 0;
  localparam int CTM_B_FLAG_P = 1;

  // ------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------
  localparam logic [7:0]  CTM_RST_BYTE  = 8'h00;
  localparam logic [15:0] CTM_RST_WORD  = 16'h0000;
  localparam logic [15:0] CTM_CNT_MAX   = 16'hFFFF;
  localparam logic [31:0] CTM_RD_UNMAP  = 32'h0000_0000;

  // Operating modes
  typedef enum logic [1:0] {
    CTM_MODE_CMP  = 2'b00,
    CTM_MODE_UNDF = 2'b01,
    CTM_MODE_PWM  = 2'b10,
    CTM_MODE_TMR  = 2'b11
  } ctm_mode_t;

  // Compare-match pin actions
  localparam logic [1:0] CTM_PA_NONE = 2'b00;
  localparam logic [1:0] CTM_PA_LOW  = 2'b01;
  localparam logic [1:0] CTM_PA_HIGH = 2'b10;
  localparam logic [1:0] CTM_PA_TOG  = 2'b11;

  // PWM pin actions
  localparam logic [1:0] CTM_PW_INACT = 2'b00;
  localparam logic [1:0] CTM_PW_ACT   = 2'b01;
  localparam logic [1:0] CTM_PW_WAVE  = 2'b10;

  // Clock-select codes for the internal divider
  localparam logic [2:0] CTM_CK_DIV4 = 3'b000;
  localparam logic [2:0] CTM_CK_SYS  = 3'b001;
  localparam logic [2:0] CTM_CK_D16  = 3'b010;
  localparam logic [2:0] CTM_CK_D64  = 3'b011;

  // Bus slave states (Gray along the path)
  typedef enum logic [1:0] {
    CTM_BUS_IDLE = 2'b00,
    CTM_BUS_ACK  = 2'b01
  } ctm_bus_t;

endpackage

// ==== design/ctm_timer.sv ====
/*
  Compact 16-bit timer: counter, compare-A/compare-P comparators, compare
  match / timer / edge-aligned PWM output, with an Avalon-MM register slave.
  Assumes one 50 MHz clock; the external count pin is synchronous to it.
*/
`timescale 1ns/1ps
module ctm_timer
  import ctm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Timer pins
  input  wire logic        i_ext_clk,
  output logic             o_pin,
  output logic             o_pin_oe,
  output logic             o_flag_a,
  output logic             o_flag_p
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  ctrl0_r;      // Pause, clock select, run enable
  logic [7:0]  ctrl1_r;      // Mode and pin controls
  logic [15:0] cmpa_r;       // Compare-A value
  logic [7:0]  cmpp_r;       // Compare-P value
  logic [15:0] cnt_r;        // Up counter
  logic        run_d_r;      // Run enable one cycle ago
  logic [5:0]  div_r;        // Prescaler
  logic        ext_d_r;      // External clock previous level
  logic        pin_r;        // Raw pin level before polarity
  logic        fa_r;         // Compare-A flag
  logic        fp_r;         // Compare-P flag
  ctm_bus_t    bus_r;        // Bus slave state

  // ------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------
  ctm_mode_t   mode;
  logic        run, pause, clrsel, dpx, octl, pol;
  logic [1:0]  pact;
  logic [2:0]  cksel;
  always_comb
  begin
    mode   = ctm_mode_t'(ctrl1_r[CTM_B_MODEHI:CTM_B_MODELO]);
    pact   = ctrl1_r[CTM_B_PINHI:CTM_B_PINLO];
    octl   = ctrl1_r[CTM_B_OCTL];
    pol    = ctrl1_r[CTM_B_POL];
    dpx    = ctrl1_r[CTM_B_DPX];
    clrsel = ctrl1_r[CTM_B_CLRSEL];
    run    = ctrl0_r[CTM_B_RUN];
    pause  = ctrl0_r[CTM_B_PAUSE];
    cksel  = ctrl0_r[CTM_B_CKHI:CTM_B_CKLO];
  end

  // ------------------------------------------------------------
  // Timer tick: one-cycle enable from the divider or the pin
  // ------------------------------------------------------------
  logic tick;
  always_comb
  begin
    case (cksel)
      CTM_CK_DIV4: tick = (div_r[1:0] == 2'h3);
      CTM_CK_SYS:  tick = 1'b1;
      CTM_CK_D16:  tick = (div_r[3:0] == 4'hF);
      CTM_CK_D64:  tick = (div_r == 6'h3F);
      3'b110:      tick = i_ext_clk & ~ext_d_r;   // Rising edge of pin
      3'b111:      tick = ~i_ext_clk & ext_d_r;   // Falling edge of pin
      default:     tick = (div_r == 6'h3F);       // Slow clock stand-in
    endcase
  end

  // Free-running prescaler and pin edge memory
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_r   <= 6'h00;
      ext_d_r <= 1'b0;
    end
    else
    begin
      div_r   <= div_r + 6'h01;
      ext_d_r <= i_ext_clk;
    end
  end

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  logic match_a, match_p, at_max, run_rise, step;
  logic clr_p, clr_a;
  always_comb
  begin
    step     = run & ~pause & tick;
    run_rise = run & ~run_d_r;
    at_max   = (cnt_r == CTM_CNT_MAX);
    // Compare-A looks at all sixteen bits; zero never matches
    match_a  = step & (cmpa_r != CTM_RST_WORD) & (cnt_r == cmpa_r - 16'h0001);
    // Compare-P compares the high byte, with the low byte at FF; zero wraps to FF, so it matches at FFFF
    match_p  = step
             & (cnt_r[15:8] == cmpp_r - 8'h01) & (cnt_r[7:0] == 8'hFF);
    // Clear sources per mode
    if (mode == CTM_MODE_PWM)
    begin
      clr_p = ~dpx;
      clr_a = dpx;
    end
    else
    begin
      clr_p = ~clrsel;
      clr_a = clrsel;
    end
  end

  // ------------------------------------------------------------
  // Counter: zero on run rise, hold on stop or pause
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r   <= CTM_RST_WORD;
      run_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= run;
      if (run_rise)
        cnt_r <= CTM_RST_WORD;
      else if (step)
      begin
        if ((clr_p & match_p) | (clr_a & match_a))
          cnt_r <= CTM_RST_WORD;
        else
          cnt_r <= cnt_r + 16'h0001;                          // wraps at max
      end
    end
  end

  // ------------------------------------------------------------
  // Event flags: set wins over a software clear
  // ------------------------------------------------------------
  logic set_a, set_p, flg_wr;
  always_comb
  begin
    // With clear-select high outside PWM the P flag is never raised
    set_p  = match_p & (clr_p | (mode == CTM_MODE_PWM));
    set_a  = match_a;
    flg_wr = (bus_r == CTM_BUS_IDLE) & i_avs_write & i_avs_byteenable[0]
           & (i_avs_address == CTM_OFS_FLAGS);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fa_r <= 1'b0;
      fp_r <= 1'b0;
    end
    else
    begin
      fa_r <= set_a | (fa_r & ~(flg_wr & i_avs_writedata[CTM_B_FLAG_A]));
      fp_r <= set_p | (fp_r & ~(flg_wr & i_avs_writedata[CTM_B_FLAG_P]));
    end
  end

  // ------------------------------------------------------------
  // PWM waveform: active while counter below duty
  // ------------------------------------------------------------
  logic [16:0] duty, period;
  logic        pwm_act;
  always_comb
  begin
    if (dpx)
    begin
      duty   = (cmpp_r == CTM_RST_BYTE) ? 17'h1_0000 : {1'b0, cmpp_r, 8'h00};
      period = (cmpa_r == CTM_RST_WORD) ? 17'h1_0000 : {1'b0, cmpa_r};
    end
    else
    begin
      duty   = {1'b0, cmpa_r};
      period = (cmpp_r == CTM_RST_BYTE) ? 17'h1_0000 : {1'b0, cmpp_r, 8'h00};
    end
    pwm_act = (duty >= period) | ({1'b0, cnt_r} < duty);
  end

  // ------------------------------------------------------------
  // Output pin (raw level, polarity applied at the port except in compare-match mode)
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_r <= 1'b0;
    else if (run_rise)
      pin_r <= (mode == CTM_MODE_PWM) ? ~octl : octl;
    else if (mode == CTM_MODE_CMP)
    begin
      if (set_a)
      begin
        case (pact)
          CTM_PA_LOW:  pin_r <= 1'b0;
          CTM_PA_HIGH: pin_r <= 1'b1;
          CTM_PA_TOG:  pin_r <= ~pin_r;
          default:     pin_r <= pin_r;
        endcase
      end
    end
    else if (mode == CTM_MODE_PWM && run)
    begin
      case (pact)
        CTM_PW_INACT: pin_r <= ~octl;
        CTM_PW_ACT:   pin_r <= octl;
        CTM_PW_WAVE:  pin_r <= pwm_act ? octl : ~octl;
        default:      pin_r <= pin_r;
      endcase
    end
  end

  // Registered port copies, polarity and output enable
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
      o_flag_a <= 1'b0;
      o_flag_p <= 1'b0;
    end
    else
    begin
      o_pin    <= (mode == CTM_MODE_CMP) ? pin_r : (pin_r ^ pol);
      o_pin_oe <= (mode == CTM_MODE_CMP) | (mode == CTM_MODE_PWM);
      o_flag_a <= fa_r;
      o_flag_p <= fp_r;
    end
  end

  // ------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the second edge
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (i_avs_address)
      CTM_OFS_CTRL0:  rd_byte = {ctrl0_r[7:3], 3'b000};
      CTM_OFS_CTRL1:  rd_byte = ctrl1_r;
      CTM_OFS_CNT_LO: rd_byte = cnt_r[7:0];
      CTM_OFS_CNT_HI: rd_byte = cnt_r[15:8];
      CTM_OFS_CMPA_L: rd_byte = cmpa_r[7:0];
      CTM_OFS_CMPA_H: rd_byte = cmpa_r[15:8];
      CTM_OFS_CMPP:   rd_byte = cmpp_r;
      CTM_OFS_FLAGS:  rd_byte = {6'h00, fp_r, fa_r};
      default:
      begin
        rd_byte = CTM_RST_BYTE;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Handshake: first cycle latches, second cycle releases waitrequest
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bus_r             <= CTM_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= CTM_RD_UNMAP;
    end
    else if (bus_r == CTM_BUS_IDLE && (i_avs_read || i_avs_write))
    begin
      bus_r             <= CTM_BUS_ACK;
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata    <= rd_hit ? {24'h00_0000, rd_byte} : CTM_RD_UNMAP;
    end
    else
    begin
      bus_r             <= CTM_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Writable registers, taken at the accept cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl0_r <= CTM_RST_BYTE;
      ctrl1_r <= CTM_RST_BYTE;
      cmpa_r  <= CTM_RST_WORD;
      cmpp_r  <= CTM_RST_BYTE;
    end
    else if (bus_r == CTM_BUS_IDLE && i_avs_write && i_avs_byteenable[0])
    begin
      case (i_avs_address)
        CTM_OFS_CTRL0:  ctrl0_r <= {i_avs_writedata[7:3], 3'b000};
        CTM_OFS_CTRL1:  ctrl1_r <= i_avs_writedata[7:0];
        CTM_OFS_CMPA_L: cmpa_r[7:0]  <= i_avs_writedata[7:0];
        CTM_OFS_CMPA_H: cmpa_r[15:8] <= i_avs_writedata[7:0];
        CTM_OFS_CMPP:   cmpp_r <= i_avs_writedata[7:0];
        default:        cmpp_r <= cmpp_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_run_rise_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    run_rise |=> (cnt_r == CTM_RST_WORD))
    else $error("counter not zero after run rise");

  a_pause_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (pause && !run_rise) |=> (cnt_r == $past(cnt_r)))
    else $error("counter moved while paused");

  a_stop_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (!run && !run_d_r) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_clr_a_match: assert property (@(posedge i_clk) disable iff (i_rst)
    (match_a && clr_a && !run_rise) |=> (cnt_r == CTM_RST_WORD) && fa_r)
    else $error("compare-A clear missing");

  a_p_flag_blocked: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == CTM_MODE_CMP && clrsel && !fp_r) |=> !fp_r || !$past(clrsel))
    else $error("compare-P flag with clear select high");

  a_p_period_clr: assert property (@(posedge i_clk) disable iff (i_rst)
    (match_p && clr_p && !run_rise) |=> (cnt_r == CTM_RST_WORD) ##0 fp_r)
    else $error("compare-P clear missing");

  a_cmp_pin_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == CTM_MODE_CMP && !set_a && !run_rise) |=> $stable(pin_r))
    else $error("pin moved without compare-A match");

  a_pin_init_lvl: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_rise && mode == CTM_MODE_CMP) |=> (pin_r == $past(octl)) ##1 (o_pin == $past(pin_r)))
    else $error("pin not loaded with initial level");

  a_full_duty: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == CTM_MODE_PWM && run && !run_rise && pact == CTM_PW_WAVE && duty >= period)
      |=> (pin_r == $past(octl)))
    else $error("full duty not held active");

  a_wrap_max: assert property (@(posedge i_clk) disable iff (i_rst)
    (step && at_max && !run_rise) |=> (cnt_r == CTM_RST_WORD))
    else $error("counter did not wrap");

endmodule // ctm_timer

// ==== test/ctm_timer_test.sv ====
/*
  Self-checking bench for the compact timer: register access, compare-match,
  timer/counter and PWM modes, pause and run control.
  Assumes ctm_pkg offsets and the one-wait-cycle Avalon-MM slave of ctm_timer.
*/
`timescale 1ns/1ps
module ctm_timer_test
  import ctm_pkg::*;
;
  // ------------------------------------------------------------
  // Design connections
  // ------------------------------------------------------------
  logic        i_clk;            // 50 MHz clock
  logic        i_rst;            // Async reset, active high
  logic [4:0]  i_avs_address;    // Register byte offset
  logic        i_avs_read;       // Read request
  logic        i_avs_write;      // Write request
  logic [31:0] i_avs_writedata;  // Write data, byte in 7:0
  logic [3:0]  i_avs_byteenable; // Lane enables
  logic [31:0] o_avs_readdata;   // Read data
  logic        o_avs_waitrequest;// Slave stall
  logic        i_ext_clk;        // External count pin, unused clock codes
  logic        o_pin;            // Timer output pin
  logic        o_pin_oe;         // Pin drive enable
  logic        o_flag_a;         // Compare-A event flag
  logic        o_flag_p;         // Compare-P event flag

  // Bench bookkeeping
  int          n_mismatch;       // Mismatches seen
  int          check_count;      // Comparisons made
  int          seed;             // Seed result, unused
  int          hi;               // High samples in a PWM window
  int          per;              // Expected PWM period
  int          dut;              // Expected PWM duty
  logic [7:0]  q, q1, r;         // Read-back and random bytes
  logic [15:0] a;                // Compare-A under test
  logic [7:0]  p;                // Compare-P under test
  logic [1:0]  act;              // Pin action
  logic        oc, po, dx;       // Output control, polarity, duty select
  logic [4:0]  ofs [5];          // Byte registers to sweep

  ctm_timer DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_ext_clk(i_ext_clk), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_flag_a(o_flag_a), .o_flag_p(o_flag_p)
  );

  // Free-running clock, 20 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Case inequality so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Bus and wait helpers
  // ------------------------------------------------------------
  // Holds the request until waitrequest is sampled low, then releases
  task automatic bus_xfer(input logic wr, input logic [4:0] ad, input logic [7:0] d,
                          input logic [3:0] be, output logic [7:0] rq);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address    <= ad;
    i_avs_read       <= ~wr;
    i_avs_write      <= wr;
    i_avs_writedata  <= {24'h00_0000, d};
    i_avs_byteenable <= be;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        chk({31'h0, o_avs_waitrequest}, 32'h0000_0000);
        close_out();
      end
      @(posedge i_clk);
    end
    rq = o_avs_readdata[7:0];
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr8(input logic [4:0] ad, input logic [7:0] d);
    logic [7:0] dummy;
    bus_xfer(1'b1, ad, d, 4'hf, dummy);
  endtask

  task automatic rd8(input logic [4:0] ad, output logic [7:0] d);
    bus_xfer(1'b0, ad, 8'h00, 4'hf, d);
  endtask

  // Bounded wait for one of the sticky flags
  task automatic wait_flag(input logic sel_p, input int lim);
    int n;
    n = 0;
    while ((sel_p ? o_flag_p : o_flag_a) !== 1'b1)
    begin
      n++;
      if (n > lim)
      begin
        chk(32'h0000_0000, 32'h0000_0001);
        close_out();
      end
      @(posedge i_clk);
    end
  endtask

  // Stop, program, clear flags, then a run rise at full clock rate
  task automatic cfg(input logic [7:0] c1, input logic [15:0] ca, input logic [7:0] cp);
    wr8(CTM_OFS_CTRL0, 8'h00);
    wr8(CTM_OFS_CTRL1, c1);
    wr8(CTM_OFS_CMPA_L, ca[7:0]);
    wr8(CTM_OFS_CMPA_H, ca[15:8]);
    wr8(CTM_OFS_CMPP, cp);
    wr8(CTM_OFS_FLAGS, 8'h03);
    wr8(CTM_OFS_CTRL0, 8'h18);
  endtask

  // High cycles per PWM period from action, active level and polarity
  function automatic int pwm_exp(int pe, int du, logic [1:0] ac, logic o, logic pl);
    int h;
    h = (ac == 2'b00) ? 0 : (ac == 2'b01) ? pe : ((du >= pe) ? pe : du);
    if (!o)
      h = pe - h;
    if (pl)
      h = pe - h;
    return h;
  endfunction

  // Timer ticks expected in 128 clocks for each internal clock code
  function automatic logic [7:0] ck_ticks(logic [2:0] c);
    return (c == 3'b000) ? 8'h20 : (c == 3'b001) ? 8'h80 : (c == 3'b010) ? 8'h08 : 8'h02;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    i_rst = 1'b1; i_avs_address = 5'h00; i_avs_read = 1'b0; i_avs_write = 1'b0;
    i_avs_writedata = 32'h0000_0000; i_avs_byteenable = 4'h0; i_ext_clk = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    ofs = '{CTM_OFS_CNT_LO, CTM_OFS_CNT_HI, CTM_OFS_CMPA_L, CTM_OFS_CMPA_H, CTM_OFS_CMPP};
    seed = $urandom(32'h7064);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values of the counter and compare byte registers
    foreach (ofs[k])
    begin
      rd8(ofs[k], q);
      chk({24'h00_0000, q}, 32'h0000_0000);
    end
    // Lane 0 disabled: write must be dropped
    bus_xfer(1'b1, CTM_OFS_CMPA_L, 8'h5a, 4'h0, q);
    rd8(CTM_OFS_CMPA_L, q);
    chk({24'h00_0000, q}, 32'h0000_0000);
    // Read/write compare bytes, read-only counter bytes
    for (int k = 0; k < 5; k++)
    begin
      r = 8'($urandom_range(1, 255));
      wr8(ofs[k], r);
      rd8(ofs[k], q);
      chk({24'h00_0000, q}, (k < 2) ? 32'h0000_0000 : {24'h00_0000, r});
    end
    // Compare-match mode, clear on A, every pin action
    for (int k = 0; k < 4; k++)
    begin
      act = 2'(k);
      oc = 1'($urandom_range(0, 1));
      cfg({2'b00, act, oc, 3'b001}, 16'h0200 + 16'($urandom_range(16, 47)), 8'h01);
      repeat (4) @(posedge i_clk);
      chk({31'h0, o_pin}, {31'h0, oc});
      chk({31'h0, o_pin_oe}, 32'h0000_0001);
      repeat (300) @(posedge i_clk);
      chk({31'h0, o_pin}, {31'h0, oc});
      wait_flag(1'b0, 1200);
      repeat (3) @(posedge i_clk);
      chk({31'h0, o_pin}, {31'h0, (act == 2'b01) ? 1'b0 : (act == 2'b10) ? 1'b1 :
          (act == 2'b11) ? ~oc : oc});
      chk({31'h0, o_flag_p}, 32'h0000_0000);
    end
    // Timer/counter mode, clear on P, both flags, pin released
    cfg({2'b11, 6'b00_0000}, 16'($urandom_range(16, 200)), 8'h01);
    wait_flag(1'b1, 600);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_flag_a}, 32'h0000_0001);
    chk({31'h0, o_pin_oe}, 32'h0000_0000);
    rd8(CTM_OFS_CNT_HI, q);
    chk({24'h00_0000, q}, 32'h0000_0000);
    // Compare-A zero: no clear, no A flag, counter climbs past one byte
    cfg(8'h01, 16'h0000, 8'h00);
    repeat (400) @(posedge i_clk);
    chk({31'h0, o_flag_a}, 32'h0000_0000);
    rd8(CTM_OFS_CNT_HI, q);
    chk({31'h0, q != 8'h00}, 32'h0000_0001);
    // Pause holds, resume continues
    wr8(CTM_OFS_CTRL0, 8'h98);
    rd8(CTM_OFS_CNT_LO, q1);
    repeat (20) @(posedge i_clk);
    rd8(CTM_OFS_CNT_LO, q);
    chk({24'h00_0000, q}, {24'h00_0000, q1});
    wr8(CTM_OFS_CTRL0, 8'h18);
    repeat (20) @(posedge i_clk);
    rd8(CTM_OFS_CNT_LO, q);
    chk({31'h0, q != q1}, 32'h0000_0001);
    // Run fall holds the count, run rise zeroes it
    wr8(CTM_OFS_CTRL0, 8'h10);
    rd8(CTM_OFS_CNT_LO, q1);
    repeat (10) @(posedge i_clk);
    rd8(CTM_OFS_CNT_LO, q);
    chk({24'h00_0000, q}, {24'h00_0000, q1});
    wr8(CTM_OFS_CTRL0, 8'h18);
    rd8(CTM_OFS_CNT_HI, q);
    chk({24'h00_0000, q}, 32'h0000_0000);
    // PWM table; clear select held high to show it is ignored
    for (int k = 0; k < 7; k++)
    begin
      a = 16'($urandom_range(1, 255));
      p = 8'h01;
      act = 2'b10;
      oc = (k != 1);
      po = (k == 2);
      dx = (k == 4);
      if (k == 3 || k == 4)
        a = 16'h0200;
      if (k == 5)
        act = 2'b00;
      if (k == 6)
        act = 2'b01;
      per = dx ? int'(a) : int'(p) * 256;
      dut = dx ? int'(p) * 256 : int'(a);
      cfg({2'b10, act, oc, po, dx, 1'b1}, a, p);
      repeat (per + 8) @(posedge i_clk);
      hi = 0;
      repeat (per)
      begin
        @(posedge i_clk);
        if (o_pin === 1'b1)
          hi++;
      end
      chk(32'(hi), 32'(pwm_exp(per, dut, act, oc, po)));
      chk({31'h0, o_flag_a}, {31'h0, dx ? 1'b1 : (int'(a) < per)});
      chk({31'h0, o_flag_p}, {31'h0, dx ? (dut < per) : 1'b1});
    end
    // Internal clock codes: count gained between samples 128 clocks apart
    for (int k = 0; k < 6; k++)
    begin
      wr8(CTM_OFS_CTRL0, {1'b0, 3'(k), 4'h8});
      rd8(CTM_OFS_CNT_LO, q1);
      repeat (125) @(posedge i_clk);
      rd8(CTM_OFS_CNT_LO, q);
      chk({24'h00_0000, 8'(q - q1)}, {24'h00_0000, ck_ticks(3'(k))});
    end
    // Pin edges as the timer clock, rising code then falling code
    for (int k = 0; k < 2; k++)
    begin
      r = 8'($urandom_range(1, 40));
      wr8(CTM_OFS_CTRL0, 8'h00);
      wr8(CTM_OFS_CTRL0, (k == 0) ? 8'h68 : 8'h78);
      repeat (r)
      begin
        @(posedge i_clk);
        i_ext_clk <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_ext_clk <= 1'b0;
        @(posedge i_clk);
      end
      rd8(CTM_OFS_CNT_LO, q);
      chk({24'h00_0000, q}, {24'h00_0000, r});
    end
    // Reset in mid-run: flag A and pin low, waitrequest high, byte registers back to zero
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({29'h0, o_flag_a, o_pin, o_avs_waitrequest}, 32'h0000_0001);
    i_rst <= 1'b0;
    foreach (ofs[k])
    begin
      rd8(ofs[k], q);
      chk({24'h00_0000, q}, 32'h0000_0000);
    end
    close_out();
  end
endmodule // ctm_timer_test
